//--- src/ifsb_pkg.sv
// Constants and types for the interrupt flag status bank
package ifsb_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int IFSB_FLAGS_W = 16;
	localparam logic [31:0] IFSB_WORD0_OFFSET = 32'h0000_0000;
	localparam logic [31:0] IFSB_WORD1_OFFSET = 32'h0000_0004;
	localparam logic [15:0] IFSB_WORD0_RESET = 16'h0000;
	localparam logic [15:0] IFSB_WORD1_RESET = 16'h0000;
	localparam logic [15:0] IFSB_WORD0_MASK = 16'h7FFF;
	localparam logic [15:0] IFSB_WORD1_MASK = 16'hFFDF;

	// ****************************************
	// Flag positions, word 0
	// ****************************************
	localparam int DMA_CH1_DONE_FLAG_BIT = 14;
	localparam int ADC_CONV_DONE_FLAG_BIT = 13;
	localparam int UART_A_TX_FLAG_BIT = 12;
	localparam int UART_A_RX_FLAG_BIT = 11;
	localparam int SPI_A_EVENT_FLAG_BIT = 10;
	localparam int SPI_A_ERROR_FLAG_BIT = 9;
	localparam int TIMER_C_FLAG_BIT = 8;
	localparam int TIMER_B_FLAG_BIT = 7;
	localparam int OUT_COMPARE_B_FLAG_BIT = 6;
	localparam int IN_CAPTURE_B_FLAG_BIT = 5;
	localparam int DMA_CH0_DONE_FLAG_BIT = 4;
	localparam int TIMER_A_FLAG_BIT = 3;
	localparam int OUT_COMPARE_A_FLAG_BIT = 2;
	localparam int IN_CAPTURE_A_FLAG_BIT = 1;
	localparam int EXT_PIN_A_FLAG_BIT = 0;

	// ****************************************
	// Flag positions, word 1, and the word 0 hole
	// ****************************************
	localparam int UART_B_TX_FLAG_BIT = 15;
	localparam int UART_B_RX_FLAG_BIT = 14;
	localparam int EXT_PIN_C_FLAG_BIT = 13;
	localparam int TIMER_E_FLAG_BIT = 12;
	localparam int TIMER_D_FLAG_BIT = 11;
	localparam int OUT_COMPARE_D_FLAG_BIT = 10;
	localparam int OUT_COMPARE_C_FLAG_BIT = 9;
	localparam int DMA_CH2_DONE_FLAG_BIT = 8;
	localparam int IN_CAPTURE_H_FLAG_BIT = 7;
	localparam int IN_CAPTURE_G_FLAG_BIT = 6;
	localparam int WORD1_HOLE_BIT = 5;
	localparam int EXT_PIN_B_FLAG_BIT = 4;
	localparam int CHANGE_NOTIFY_FLAG_BIT = 3;
	localparam int COMPARATOR_EVENT_FLAG_BIT = 2;
	localparam int I2C_MASTER_EVENT_FLAG_BIT = 1;
	localparam int I2C_SLAVE_EVENT_FLAG_BIT = 0;
	localparam int WORD0_HOLE_BIT = 15;

	// ****************************************
	// Bus answers and states
	// ****************************************
	localparam logic [1:0] IFSB_RESP_OKAY = 2'b00;
	localparam logic [1:0] IFSB_RESP_SLVERR = 2'b10;
	localparam logic [1:0] IFSB_SEL_WORD0 = 2'b00;
	localparam logic [1:0] IFSB_SEL_WORD1 = 2'b01;
	localparam logic [1:0] IFSB_SEL_NONE = 2'b10;

	typedef enum logic [1:0] {
		IFSB_WR_IDLE = 2'b00,
		IFSB_WR_RESP = 2'b01,
		IFSB_WR_DATA = 2'b11,
		IFSB_WR_ADDR = 2'b10
	} ifsb_wr_state_t;

	typedef enum logic {
		IFSB_RD_IDLE = 1'b0,
		IFSB_RD_RESP = 1'b1
	} ifsb_rd_state_t;

endpackage

//--- src/ifsb_top.sv
// Interrupt flag status bank with an AXI4-Lite register slave
`timescale 1ns/100ps

module ifsb_top import ifsb_pkg::*; #(
	parameter int AXI_ADDR_W = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic evt_dma_ch0_done,
	input wire logic evt_dma_ch1_done,
	input wire logic evt_dma_ch2_done,
	input wire logic evt_adc_conv_done,
	input wire logic evt_uart_a_tx,
	input wire logic evt_uart_a_rx,
	input wire logic evt_uart_b_tx,
	input wire logic evt_uart_b_rx,
	input wire logic evt_spi_a_event,
	input wire logic evt_spi_a_error,
	input wire logic evt_timer_a,
	input wire logic evt_timer_b,
	input wire logic evt_timer_c,
	input wire logic evt_timer_d,
	input wire logic evt_timer_e,
	input wire logic evt_out_compare_a,
	input wire logic evt_out_compare_b,
	input wire logic evt_out_compare_c,
	input wire logic evt_out_compare_d,
	input wire logic evt_in_capture_a,
	input wire logic evt_in_capture_b,
	input wire logic evt_in_capture_g,
	input wire logic evt_in_capture_h,
	input wire logic evt_ext_pin_a,
	input wire logic evt_ext_pin_b,
	input wire logic evt_ext_pin_c,
	input wire logic evt_change_notify,
	input wire logic evt_comparator,
	input wire logic evt_i2c_master,
	input wire logic evt_i2c_slave,
	output logic [15:0] interrupt_flags_word_0,
	output logic [15:0] interrupt_flags_word_1
);

	// ****************************************
	// Elaboration check
	// ****************************************
	if (AXI_ADDR_W < 3 || AXI_ADDR_W > 32) begin : g_bad_addr_w
		$error("AXI_ADDR_W must lie between 3 and 32");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ifsb_wr_state_t wr_state;
		logic [AXI_ADDR_W-1:0] wr_addr;
		logic [31:0] wr_data;
		logic [3:0] wr_strb;
		logic [1:0] bresp;
		ifsb_rd_state_t rd_state;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] flags0;
		logic [15:0] flags1;
	} ifsb_state_t;

	ifsb_state_t st_q;
	ifsb_state_t st_d;

	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_go;
	logic wr_hit0;
	logic wr_hit1;
	logic [AXI_ADDR_W-1:0] wr_addr_eff;
	logic [31:0] wr_data_eff;
	logic [3:0] wr_strb_eff;
	logic [15:0] set0;
	logic [15:0] set1;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [1:0] ifsb_decode(input logic [AXI_ADDR_W-1:0] addr);
		logic [31:0] word_addr;
		word_addr = 32'(addr) & ~32'h0000_0003;
		if (word_addr == IFSB_WORD0_OFFSET) begin
			return IFSB_SEL_WORD0;
		end else if (word_addr == IFSB_WORD1_OFFSET) begin
			return IFSB_SEL_WORD1;
		end else begin
			return IFSB_SEL_NONE;
		end
	endfunction

	function automatic logic [15:0] ifsb_merge(input logic [15:0] old_val,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old_val;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// ****************************************
	// Event routing, word 0
	// ****************************************
	// hole stays clear
	assign set0[WORD0_HOLE_BIT] = 1'b0;
	assign set0[DMA_CH1_DONE_FLAG_BIT] = evt_dma_ch1_done;
	assign set0[DMA_CH0_DONE_FLAG_BIT] = evt_dma_ch0_done;
	assign set0[ADC_CONV_DONE_FLAG_BIT] = evt_adc_conv_done;
	assign set0[UART_A_TX_FLAG_BIT] = evt_uart_a_tx;
	assign set0[UART_A_RX_FLAG_BIT] = evt_uart_a_rx;
	assign set0[SPI_A_EVENT_FLAG_BIT] = evt_spi_a_event;
	assign set0[SPI_A_ERROR_FLAG_BIT] = evt_spi_a_error;
	assign set0[TIMER_C_FLAG_BIT] = evt_timer_c;
	assign set0[TIMER_B_FLAG_BIT] = evt_timer_b;
	assign set0[TIMER_A_FLAG_BIT] = evt_timer_a;
	assign set0[OUT_COMPARE_B_FLAG_BIT] = evt_out_compare_b;
	assign set0[OUT_COMPARE_A_FLAG_BIT] = evt_out_compare_a;
	assign set0[IN_CAPTURE_B_FLAG_BIT] = evt_in_capture_b;
	assign set0[IN_CAPTURE_A_FLAG_BIT] = evt_in_capture_a;
	assign set0[EXT_PIN_A_FLAG_BIT] = evt_ext_pin_a;

	// ****************************************
	// Event routing, word 1
	// ****************************************
	// Second UART sets
	assign set1[UART_B_TX_FLAG_BIT] = evt_uart_b_tx;
	assign set1[UART_B_RX_FLAG_BIT] = evt_uart_b_rx;
	assign set1[EXT_PIN_C_FLAG_BIT] = evt_ext_pin_c;
	assign set1[EXT_PIN_B_FLAG_BIT] = evt_ext_pin_b;
	assign set1[TIMER_E_FLAG_BIT] = evt_timer_e;
	assign set1[TIMER_D_FLAG_BIT] = evt_timer_d;
	assign set1[OUT_COMPARE_D_FLAG_BIT] = evt_out_compare_d;
	assign set1[OUT_COMPARE_C_FLAG_BIT] = evt_out_compare_c;
	assign set1[DMA_CH2_DONE_FLAG_BIT] = evt_dma_ch2_done;
	assign set1[IN_CAPTURE_H_FLAG_BIT] = evt_in_capture_h;
	assign set1[IN_CAPTURE_G_FLAG_BIT] = evt_in_capture_g;
	assign set1[WORD1_HOLE_BIT] = 1'b0;
	assign set1[CHANGE_NOTIFY_FLAG_BIT] = evt_change_notify;
	assign set1[COMPARATOR_EVENT_FLAG_BIT] = evt_comparator;
	assign set1[I2C_MASTER_EVENT_FLAG_BIT] = evt_i2c_master;
	assign set1[I2C_SLAVE_EVENT_FLAG_BIT] = evt_i2c_slave;

	// ****************************************
	// Bus handshakes
	// ****************************************
	assign s_axi_awready = (st_q.wr_state == IFSB_WR_IDLE) || (st_q.wr_state == IFSB_WR_DATA);
	assign s_axi_wready = (st_q.wr_state == IFSB_WR_IDLE) || (st_q.wr_state == IFSB_WR_ADDR);
	assign s_axi_bvalid = (st_q.wr_state == IFSB_WR_RESP);
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = (st_q.rd_state == IFSB_RD_IDLE);
	assign s_axi_rvalid = (st_q.rd_state == IFSB_RD_RESP);
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign interrupt_flags_word_0 = st_q.flags0;
	assign interrupt_flags_word_1 = st_q.flags1;

	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign wr_addr_eff = aw_fire ? s_axi_awaddr : st_q.wr_addr;
	assign wr_data_eff = w_fire ? s_axi_wdata : st_q.wr_data;
	assign wr_strb_eff = w_fire ? s_axi_wstrb : st_q.wr_strb;
	assign wr_go = (aw_fire || st_q.wr_state == IFSB_WR_ADDR)
		&& (w_fire || st_q.wr_state == IFSB_WR_DATA);
	assign wr_hit0 = wr_go && (ifsb_decode(wr_addr_eff) == IFSB_SEL_WORD0);
	assign wr_hit1 = wr_go && (ifsb_decode(wr_addr_eff) == IFSB_SEL_WORD1);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		// Write channel
		case (st_q.wr_state)
			IFSB_WR_IDLE: begin
				if (wr_go) begin
					st_d.wr_state = IFSB_WR_RESP;
				end else if (aw_fire) begin
					st_d.wr_state = IFSB_WR_ADDR;
				end else if (w_fire) begin
					st_d.wr_state = IFSB_WR_DATA;
				end
			end
			IFSB_WR_ADDR: begin
				if (wr_go) begin
					st_d.wr_state = IFSB_WR_RESP;
				end
			end
			IFSB_WR_DATA: begin
				if (wr_go) begin
					st_d.wr_state = IFSB_WR_RESP;
				end
			end
			IFSB_WR_RESP: begin
				if (s_axi_bready) begin
					st_d.wr_state = IFSB_WR_IDLE;
				end
			end
			default: begin
				st_d.wr_state = IFSB_WR_IDLE;
			end
		endcase
		if (aw_fire) begin
			st_d.wr_addr = s_axi_awaddr;
		end
		if (w_fire) begin
			st_d.wr_data = s_axi_wdata;
			st_d.wr_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			st_d.bresp = (wr_hit0 || wr_hit1) ? IFSB_RESP_OKAY : IFSB_RESP_SLVERR;
		end
		// Read channel
		case (st_q.rd_state)
			IFSB_RD_IDLE: begin
				if (ar_fire) begin
					st_d.rd_state = IFSB_RD_RESP;
					st_d.rresp = IFSB_RESP_OKAY;
					case (ifsb_decode(s_axi_araddr))
						IFSB_SEL_WORD0: begin
							st_d.rdata = {16'h0000, st_q.flags0};
						end
						IFSB_SEL_WORD1: begin
							st_d.rdata = {16'h0000, st_q.flags1};
						end
						default: begin
							st_d.rdata = 32'h0000_0000;
							st_d.rresp = IFSB_RESP_SLVERR;
						end
					endcase
				end
			end
			IFSB_RD_RESP: begin
				if (s_axi_rready) begin
					st_d.rd_state = IFSB_RD_IDLE;
				end
			end
			default: begin
				st_d.rd_state = IFSB_RD_IDLE;
			end
		endcase
		// software write of the flag word
		if (wr_hit0) begin
			st_d.flags0 = ifsb_merge(st_q.flags0, wr_data_eff, wr_strb_eff);
		end
		if (wr_hit1) begin
			st_d.flags1 = ifsb_merge(st_q.flags1, wr_data_eff, wr_strb_eff);
		end
		st_d.flags0 = (st_d.flags0 | set0) & IFSB_WORD0_MASK;
		st_d.flags1 = (st_d.flags1 | set1) & IFSB_WORD1_MASK;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.wr_state <= IFSB_WR_IDLE;
			st_q.rd_state <= IFSB_RD_IDLE;
			st_q.bresp <= IFSB_RESP_OKAY;
			st_q.rresp <= IFSB_RESP_OKAY;
			st_q.flags0 <= IFSB_WORD0_RESET;
			st_q.flags1 <= IFSB_WORD1_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_HOLES_ZERO: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!st_q.flags0[WORD0_HOLE_BIT] && !st_q.flags1[WORD1_HOLE_BIT])
		else $error("Unimplemented flag bit reads one");

	AST_READ_WORD0: assert property (
		@(posedge core_clk) disable iff (!resetn)
		ar_fire && ifsb_decode(s_axi_araddr) == IFSB_SEL_WORD0
		|=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(st_q.flags0)})
		else $error("Read of word 0 returned wrong data");

	AST_FULL_WRITE1: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr_hit1 && wr_strb_eff[1:0] == 2'b11 && set1 == 16'h0000
		|=> st_q.flags1 == ($past(wr_data_eff[15:0]) & IFSB_WORD1_MASK))
		else $error("Write to word 1 not stored");

	AST_SET_WORD0: assert property (
		@(posedge core_clk) disable iff (!resetn)
		set0 != 16'h0000 |=> (st_q.flags0 & $past(set0)) == $past(set0))
		else $error("Word 0 event did not set its flag");

	AST_NO_SPURIOUS1: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!wr_hit1 && set1 == 16'h0000 |=> $stable(st_q.flags1))
		else $error("Word 1 flag changed with no cause");

	AST_DMA1_BIT: assert property (
		@(posedge core_clk) disable iff (!resetn)
		evt_dma_ch1_done |=> st_q.flags0[DMA_CH1_DONE_FLAG_BIT])
		else $error("DMA channel 1 flag not set");

	AST_I2C_SLAVE_BIT: assert property (
		@(posedge core_clk) disable iff (!resetn)
		evt_i2c_slave |=> interrupt_flags_word_1[I2C_SLAVE_EVENT_FLAG_BIT])
		else $error("I2C slave flag not set");

	AST_STICKY0: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!wr_hit0 |=> (st_q.flags0 & $past(st_q.flags0)) == $past(st_q.flags0))
		else $error("Word 0 flag dropped without a write");

	AST_SET_BEATS_CLEAR: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr_hit0 && evt_ext_pin_a |=> st_q.flags0[EXT_PIN_A_FLAG_BIT])
		else $error("Clear beat a hardware set");

	AST_BVALID_HOLD: assert property (
		@(posedge core_clk) disable iff (!resetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");

	AST_BRESP_TIMING: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr_go |=> s_axi_bvalid)
		else $error("Write response late");

	AST_RVALID_HOLD: assert property (
		@(posedge core_clk) disable iff (!resetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data changed before taken");

endmodule

//--- tb/ifsb_evt_src.sv
// Peripheral event sources that strobe the flag bank
`timescale 1ns/100ps

module ifsb_evt_src (
	input wire logic [15:0] fire0,
	input wire logic [15:0] fire1,
	output logic evt_dma_ch0_done,
	output logic evt_dma_ch1_done,
	output logic evt_dma_ch2_done,
	output logic evt_adc_conv_done,
	output logic evt_uart_a_tx,
	output logic evt_uart_a_rx,
	output logic evt_uart_b_tx,
	output logic evt_uart_b_rx,
	output logic evt_spi_a_event,
	output logic evt_spi_a_error,
	output logic evt_timer_a,
	output logic evt_timer_b,
	output logic evt_timer_c,
	output logic evt_timer_d,
	output logic evt_timer_e,
	output logic evt_out_compare_a,
	output logic evt_out_compare_b,
	output logic evt_out_compare_c,
	output logic evt_out_compare_d,
	output logic evt_in_capture_a,
	output logic evt_in_capture_b,
	output logic evt_in_capture_g,
	output logic evt_in_capture_h,
	output logic evt_ext_pin_a,
	output logic evt_ext_pin_b,
	output logic evt_ext_pin_c,
	output logic evt_change_notify,
	output logic evt_comparator,
	output logic evt_i2c_master,
	output logic evt_i2c_slave
);
	// ****************************************
	// Source strobes, one per flag position
	// ****************************************
	assign {evt_dma_ch1_done, evt_adc_conv_done, evt_uart_a_tx, evt_uart_a_rx, evt_spi_a_event,
		evt_spi_a_error, evt_timer_c, evt_timer_b, evt_out_compare_b, evt_in_capture_b,
		evt_dma_ch0_done, evt_timer_a, evt_out_compare_a, evt_in_capture_a,
		evt_ext_pin_a} = fire0[14:0];
	assign {evt_uart_b_tx, evt_uart_b_rx, evt_ext_pin_c, evt_timer_e, evt_timer_d,
		evt_out_compare_d, evt_out_compare_c, evt_dma_ch2_done, evt_in_capture_h,
		evt_in_capture_g} = fire1[15:6];
	assign {evt_ext_pin_b, evt_change_notify, evt_comparator, evt_i2c_master,
		evt_i2c_slave} = fire1[4:0];
endmodule

//--- tb/ifsb_top_tb_top.sv
// Self-checking testbench for the interrupt flag status bank
`timescale 1ns/100ps

module ifsb_top_tb_top import ifsb_pkg::*;;
	logic core_clk, resetn, wr_hit, rnd_evt;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] interrupt_flags_word_0, interrupt_flags_word_1, fire0, fire1, exp0_q, exp1_q;
	logic evt_dma_ch0_done, evt_dma_ch1_done, evt_dma_ch2_done, evt_adc_conv_done, evt_uart_a_tx;
	logic evt_uart_a_rx, evt_uart_b_tx, evt_uart_b_rx, evt_spi_a_event, evt_spi_a_error;
	logic evt_timer_a, evt_timer_b, evt_timer_c, evt_timer_d, evt_timer_e, evt_out_compare_a;
	logic evt_out_compare_b, evt_out_compare_c, evt_out_compare_d, evt_in_capture_a;
	logic evt_in_capture_b, evt_in_capture_g, evt_in_capture_h, evt_ext_pin_a, evt_ext_pin_b;
	logic evt_ext_pin_c, evt_change_notify, evt_comparator, evt_i2c_master, evt_i2c_slave;
	int miscompares, n_checks;

	ifsb_top #(.AXI_ADDR_W(4)) u_ifsb_top (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt_dma_ch0_done,
		.evt_dma_ch1_done, .evt_dma_ch2_done, .evt_adc_conv_done, .evt_uart_a_tx, .evt_uart_a_rx,
		.evt_uart_b_tx, .evt_uart_b_rx, .evt_spi_a_event, .evt_spi_a_error, .evt_timer_a,
		.evt_timer_b, .evt_timer_c, .evt_timer_d, .evt_timer_e, .evt_out_compare_a,
		.evt_out_compare_b, .evt_out_compare_c, .evt_out_compare_d, .evt_in_capture_a,
		.evt_in_capture_b, .evt_in_capture_g, .evt_in_capture_h, .evt_ext_pin_a, .evt_ext_pin_b,
		.evt_ext_pin_c, .evt_change_notify, .evt_comparator, .evt_i2c_master, .evt_i2c_slave,
		.interrupt_flags_word_0, .interrupt_flags_word_1);

	ifsb_evt_src u_ifsb_evt_src (.fire0, .fire1, .evt_dma_ch0_done, .evt_dma_ch1_done,
		.evt_dma_ch2_done, .evt_adc_conv_done, .evt_uart_a_tx, .evt_uart_a_rx, .evt_uart_b_tx,
		.evt_uart_b_rx, .evt_spi_a_event, .evt_spi_a_error, .evt_timer_a, .evt_timer_b,
		.evt_timer_c, .evt_timer_d, .evt_timer_e, .evt_out_compare_a, .evt_out_compare_b,
		.evt_out_compare_c, .evt_out_compare_d, .evt_in_capture_a, .evt_in_capture_b,
		.evt_in_capture_g, .evt_in_capture_h, .evt_ext_pin_a, .evt_ext_pin_b, .evt_ext_pin_c,
		.evt_change_notify, .evt_comparator, .evt_i2c_master, .evt_i2c_slave);

	// ****************************************
	// Expected flags
	// ****************************************
	function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] st, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{st[1]}}, {8{st[0]}}};
		return ((old & ~lanes) | (d[15:0] & lanes)) & mask;
	endfunction

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			exp0_q <= IFSB_WORD0_RESET;
			exp1_q <= IFSB_WORD1_RESET;
		end else begin
			wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
			exp0_q <= (wr_hit && s_axi_awaddr[3:2] == 2'd0 ?
				wr_merge(exp0_q, s_axi_wdata, s_axi_wstrb, IFSB_WORD0_MASK) : exp0_q) |
				(fire0 & IFSB_WORD0_MASK);
			exp1_q <= (wr_hit && s_axi_awaddr[3:2] == 2'd1 ?
				wr_merge(exp1_q, s_axi_wdata, s_axi_wstrb, IFSB_WORD1_MASK) : exp1_q) |
				(fire1 & IFSB_WORD1_MASK);
		end
	end

	// ****************************************
	// Checks and bus tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask

	always @(negedge core_clk) begin
		if (resetn === 1'b1) begin
			check("flags word 0", {16'h0000, exp0_q}, {16'h0000, interrupt_flags_word_0});
			check("flags word 1", {16'h0000, exp1_q}, {16'h0000, interrupt_flags_word_1});
		end
	end

	task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge core_clk);
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("write answer", 32'h0000_0001, {31'h0, s_axi_bvalid});
		check("write resp", {30'h0, a[3] ? IFSB_RESP_SLVERR : IFSB_RESP_OKAY}, {30'h0, s_axi_bresp});
		@(posedge core_clk);
	endtask

	task automatic rd_chk(input logic [3:0] a);
		logic [31:0] e;
		e = 32'h0000_0000;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		if (a[3:2] == 2'd0) e = {16'h0000, exp0_q};
		if (a[3:2] == 2'd1) e = {16'h0000, exp1_q};
		do begin
			@(posedge core_clk);
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check("read answer", 32'h0000_0001, {31'h0, s_axi_rvalid});
		check("read data", e, s_axi_rdata);
		check("read resp", {30'h0, a[3] ? IFSB_RESP_SLVERR : IFSB_RESP_OKAY}, {30'h0, s_axi_rresp});
		@(posedge core_clk);
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, random events, watchdog
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (rnd_evt) begin
			fire0 <= 16'($urandom & $urandom & $urandom);
			fire1 <= 16'($urandom & $urandom & $urandom);
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		print_verdict();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		miscompares = 0;
		n_checks = 0;
		resetn = 1'b0;
		rnd_evt = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		fire0 = 16'h0000;
		fire1 = 16'h0000;
		void'($urandom(39460));
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd_chk(4'h0);
		rd_chk(4'h4);
		wr_chk(4'h0, 32'hFFFF_FFFF, 4'hF);
		wr_chk(4'h7, 32'hFFFF_FFFF, 4'hF);
		rd_chk(4'h1);
		rd_chk(4'h4);
		wr_chk(4'h0, 32'h0000_0000, 4'h1);
		rd_chk(4'h0);
		wr_chk(4'h8, 32'h0000_0000, 4'hF);
		rd_chk(4'hC);
		for (int i = 0; i < 16; i++) begin
			wr_chk(4'h0, 32'h0000_0000, 4'h3);
			wr_chk(4'h4, 32'h0000_0000, 4'h3);
			fire0 <= 16'h0001 << i;
			fire1 <= 16'h0001 << i;
			@(posedge core_clk);
			fire0 <= 16'h0000;
			fire1 <= 16'h0000;
			repeat (3) @(posedge core_clk);
			rd_chk(4'h0);
			rd_chk(4'h4);
		end
		fire0 <= 16'hFFFF;
		fire1 <= 16'hFFFF;
		wr_chk(4'h0, 32'h0000_0000, 4'hF);
		wr_chk(4'h4, 32'h0000_0000, 4'hF);
		fire0 <= 16'h0000;
		fire1 <= 16'h0000;
		rd_chk(4'h0);
		rd_chk(4'h4);
		rnd_evt = 1'b1;
		repeat (300) begin
			if ($urandom_range(1, 0) == 1) begin
				wr_chk(4'($urandom), $urandom, 4'($urandom));
			end else begin
				rd_chk(4'($urandom));
			end
		end
		rnd_evt = 1'b0;
		fire0 <= 16'h0000;
		fire1 <= 16'h0000;
		wr_chk(4'h0, 32'h0000_FFFF, 4'h3);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd_chk(4'h0);
		rd_chk(4'h4);
		print_verdict();
	end
endmodule
